// ===== shared/aad_pkg.sv
// Package with types and constants for the accumulator add and AND datapath
package aad_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned NIB_W  = 4;

  localparam logic [DATA_W-1:0] ACC_RST   = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

  // Operation codes presented by the decoder with a request
  typedef enum logic [2:0] {
    OP_NONE                = 3'h0,
    OP_ADD_ACC_INTO_MEMORY = 3'h1,
    OP_AND_MEM_INTO_ACC    = 3'h2,
    OP_AND_IMM_INTO_ACC    = 3'h3,
    OP_AND_ACC_INTO_MEMORY = 3'h4,
    OP_LOAD_ACC_IMM        = 3'h5
  } aad_op_t;

  // Status flags, one bit each
  typedef struct packed {
    logic overflow_flag;
    logic zero_flag;
    logic aux_carry_flag;
    logic carry_flag;
    logic signed_compare_flag;
  } aad_flags_t;

  localparam aad_flags_t FLAGS_RST = '{default: 1'b0};

  // Request from the decoder; the memory byte is the addressed data-memory operand
  typedef struct packed {
    logic              valid;
    aad_op_t           op;
    logic [DATA_W-1:0] mem_rdata;
    logic [DATA_W-1:0] imm;
  } aad_req_t;

  // Write-back towards the addressed data-memory byte
  typedef struct packed {
    logic              we;
    logic [DATA_W-1:0] wdata;
  } aad_mem_wr_t;

  // All state of the datapath
  typedef struct packed {
    logic [DATA_W-1:0] accumulator_reg;
    aad_flags_t        flags;
    aad_mem_wr_t       mem_wr;
    logic              done;
  } aad_state_t;

endpackage

// ===== src/aad_datapath.sv
// Accumulator add-into-memory and AND datapath with status flag update
`timescale 1ns/1ns
// How it works
// - Add into memory writes accumulator plus memory byte back; sets all five flags.
// - AND memory into accumulator places accumulator AND memory byte in accumulator.
// - AND memory into accumulator changes only the zero flag.
// - AND immediate stores accumulator AND immediate in accumulator; only zero flag changes.
// - AND-into-memory writes memory byte AND accumulator to that memory byte.
module aad_datapath (
  input  wire logic                             CLK_SYS,
  input  wire logic                             RST_N,
  input  wire aad_pkg::aad_req_t                REQ,
  output logic        [aad_pkg::DATA_W-1:0]     ACC_OUT,
  output aad_pkg::aad_flags_t                   FLAGS_OUT,
  output aad_pkg::aad_mem_wr_t                  MEM_WR,
  output logic                                  DONE
);

  aad_pkg::aad_state_t             st_ff;
  aad_pkg::aad_state_t             nxt_st;
  logic [aad_pkg::DATA_W:0]        sum9;
  logic [aad_pkg::NIB_W:0]         nib_sum;
  logic [aad_pkg::DATA_W-1:0]      low7_sum;
  logic [aad_pkg::DATA_W-1:0]      and_mem;
  logic [aad_pkg::DATA_W-1:0]      and_imm;
  logic                            add_ov;

  function automatic logic is_zero(input logic [aad_pkg::DATA_W-1:0] v);
    is_zero = (v == aad_pkg::ZERO_BYTE);
  endfunction

  // Carry into bit 7 is taken from a 7-bit sum so overflow needs no signed arithmetic
  always_comb begin
    sum9     = {1'b0, st_ff.accumulator_reg} + {1'b0, REQ.mem_rdata};
    nib_sum  = {1'b0, st_ff.accumulator_reg[aad_pkg::NIB_W-1:0]}
             + {1'b0, REQ.mem_rdata[aad_pkg::NIB_W-1:0]};
    low7_sum = {1'b0, st_ff.accumulator_reg[aad_pkg::DATA_W-2:0]}
             + {1'b0, REQ.mem_rdata[aad_pkg::DATA_W-2:0]};
    add_ov   = low7_sum[aad_pkg::DATA_W-1] ^ sum9[aad_pkg::DATA_W];
    and_mem  = st_ff.accumulator_reg & REQ.mem_rdata;
    and_imm  = st_ff.accumulator_reg & REQ.imm;
    nxt_st           = st_ff;
    nxt_st.mem_wr.we = 1'b0;
    nxt_st.done      = 1'b0;
    if (REQ.valid) begin
      nxt_st.done = 1'b1;
      case (REQ.op)
        aad_pkg::OP_ADD_ACC_INTO_MEMORY: begin
          nxt_st.mem_wr.we                  = 1'b1;
          nxt_st.mem_wr.wdata               = sum9[aad_pkg::DATA_W-1:0];
          nxt_st.flags.overflow_flag        = add_ov;
          nxt_st.flags.zero_flag            = is_zero(sum9[aad_pkg::DATA_W-1:0]);
          nxt_st.flags.aux_carry_flag       = nib_sum[aad_pkg::NIB_W];
          nxt_st.flags.carry_flag           = sum9[aad_pkg::DATA_W];
          // Signed compare: sign of the true result, overflow corrected
          nxt_st.flags.signed_compare_flag  = add_ov ^ sum9[aad_pkg::DATA_W-1];
        end
        aad_pkg::OP_AND_MEM_INTO_ACC: begin
          nxt_st.accumulator_reg  = and_mem;
          nxt_st.flags.zero_flag  = is_zero(and_mem);
        end
        aad_pkg::OP_AND_IMM_INTO_ACC: begin
          nxt_st.accumulator_reg  = and_imm;
          nxt_st.flags.zero_flag  = is_zero(and_imm);
        end
        aad_pkg::OP_AND_ACC_INTO_MEMORY: begin
          nxt_st.mem_wr.we        = 1'b1;
          nxt_st.mem_wr.wdata     = and_mem;
          nxt_st.flags.zero_flag  = is_zero(and_mem);
        end
        aad_pkg::OP_LOAD_ACC_IMM: begin
          // Loading the accumulator leaves every flag alone
          nxt_st.accumulator_reg = REQ.imm;
        end
        default: begin
          // Unknown codes are dropped without a pulse so the decoder may idle on them
          nxt_st.done = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      // Clearing the strobe keeps a mid-run reset from replaying a write-back
      st_ff.accumulator_reg <= aad_pkg::ACC_RST;
      st_ff.flags           <= aad_pkg::FLAGS_RST;
      st_ff.mem_wr.we       <= 1'b0;
      st_ff.mem_wr.wdata    <= aad_pkg::ZERO_BYTE;
      st_ff.done            <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ACC_OUT   = st_ff.accumulator_reg;
  assign FLAGS_OUT = st_ff.flags;
  assign MEM_WR    = st_ff.mem_wr;
  assign DONE      = st_ff.done;

  chk_add_writes_sum: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.valid && REQ.op == aad_pkg::OP_ADD_ACC_INTO_MEMORY) |=>
      (MEM_WR.we && MEM_WR.wdata == 8'($past(ACC_OUT) + $past(REQ.mem_rdata))
       && FLAGS_OUT.carry_flag == (({1'b0, $past(ACC_OUT)} + {1'b0, $past(REQ.mem_rdata)})
                                   > 9'h0ff)
       && ACC_OUT == $past(ACC_OUT)))
    else $error("add into memory gave wrong sum or carry");

  chk_and_mem_acc: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.valid && REQ.op == aad_pkg::OP_AND_MEM_INTO_ACC) |=>
      (ACC_OUT == ($past(ACC_OUT) & $past(REQ.mem_rdata)) && !MEM_WR.we))
    else $error("AND memory into accumulator result wrong");

  chk_and_mem_flags: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.valid && REQ.op == aad_pkg::OP_AND_MEM_INTO_ACC) |=>
      (FLAGS_OUT.overflow_flag == $past(FLAGS_OUT.overflow_flag)
       && FLAGS_OUT.carry_flag == $past(FLAGS_OUT.carry_flag)
       && FLAGS_OUT.aux_carry_flag == $past(FLAGS_OUT.aux_carry_flag)
       && FLAGS_OUT.signed_compare_flag == $past(FLAGS_OUT.signed_compare_flag)))
    else $error("AND memory into accumulator disturbed a flag other than zero");

  chk_and_imm_acc: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.valid && REQ.op == aad_pkg::OP_AND_IMM_INTO_ACC) |=>
      (ACC_OUT == ($past(ACC_OUT) & $past(REQ.imm))
       && FLAGS_OUT.carry_flag == $past(FLAGS_OUT.carry_flag)
       && FLAGS_OUT.overflow_flag == $past(FLAGS_OUT.overflow_flag)))
    else $error("AND immediate result or flags wrong");

  chk_and_into_mem: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.valid && REQ.op == aad_pkg::OP_AND_ACC_INTO_MEMORY) |=>
      (MEM_WR.we && MEM_WR.wdata == ($past(ACC_OUT) & $past(REQ.mem_rdata))
       && ACC_OUT == $past(ACC_OUT)) ##1 (!MEM_WR.we || $past(REQ.valid)))
    else $error("AND into memory write-back wrong");

  chk_zero_flag: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (DONE && MEM_WR.we) |-> (FLAGS_OUT.zero_flag == (MEM_WR.wdata == 8'h00)))
    else $error("zero flag disagrees with memory result");

  chk_zero_acc: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.valid && (REQ.op == aad_pkg::OP_AND_MEM_INTO_ACC
                   || REQ.op == aad_pkg::OP_AND_IMM_INTO_ACC)) |=>
      (FLAGS_OUT.zero_flag == (ACC_OUT == 8'h00)))
    else $error("zero flag disagrees with accumulator result");

  chk_idle_quiet: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !REQ.valid |=> (!DONE && !MEM_WR.we && $stable(ACC_OUT) && $stable(FLAGS_OUT)))
    else $error("state changed without a request");

  // Flag checks below use sign and nibble arithmetic of their own, not the datapath's
  chk_add_overflow: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.valid && REQ.op == aad_pkg::OP_ADD_ACC_INTO_MEMORY) |=>
      (FLAGS_OUT.overflow_flag == (($past(ACC_OUT[7]) == $past(REQ.mem_rdata[7]))
                                   && (MEM_WR.wdata[7] != $past(ACC_OUT[7])))))
    else $error("add into memory overflow flag wrong");

  chk_add_aux_carry: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.valid && REQ.op == aad_pkg::OP_ADD_ACC_INTO_MEMORY) |=>
      (FLAGS_OUT.aux_carry_flag
       == (({1'b0, $past(ACC_OUT[3:0])} + {1'b0, $past(REQ.mem_rdata[3:0])}) > 5'h0f)))
    else $error("add into memory aux carry flag wrong");

  chk_add_signed_cmp: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.valid && REQ.op == aad_pkg::OP_ADD_ACC_INTO_MEMORY) |=>
      (FLAGS_OUT.signed_compare_flag
       == ($past(ACC_OUT[7]) ^ $past(REQ.mem_rdata[7]) ^ FLAGS_OUT.carry_flag)))
    else $error("add into memory signed compare flag wrong");

  chk_add_zero: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.valid && REQ.op == aad_pkg::OP_ADD_ACC_INTO_MEMORY) |=>
      (FLAGS_OUT.zero_flag == (MEM_WR.wdata == 8'h00)))
    else $error("add into memory zero flag wrong");

  chk_and_imm_flags: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.valid && REQ.op == aad_pkg::OP_AND_IMM_INTO_ACC) |=>
      (FLAGS_OUT.aux_carry_flag == $past(FLAGS_OUT.aux_carry_flag)
       && FLAGS_OUT.signed_compare_flag == $past(FLAGS_OUT.signed_compare_flag)
       && !MEM_WR.we && $stable(MEM_WR.wdata)))
    else $error("AND immediate disturbed a flag or the memory byte");

  chk_and_mem_keep: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.valid && REQ.op == aad_pkg::OP_AND_MEM_INTO_ACC) |=> $stable(MEM_WR.wdata))
    else $error("AND memory into accumulator touched the memory byte");

  chk_store_flags: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.valid && REQ.op == aad_pkg::OP_AND_ACC_INTO_MEMORY) |=>
      (FLAGS_OUT.overflow_flag == $past(FLAGS_OUT.overflow_flag)
       && FLAGS_OUT.carry_flag == $past(FLAGS_OUT.carry_flag)
       && FLAGS_OUT.aux_carry_flag == $past(FLAGS_OUT.aux_carry_flag)
       && FLAGS_OUT.signed_compare_flag == $past(FLAGS_OUT.signed_compare_flag)))
    else $error("AND into memory disturbed a flag other than zero");

  chk_store_zero: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.valid && REQ.op == aad_pkg::OP_AND_ACC_INTO_MEMORY) |=>
      (FLAGS_OUT.zero_flag == (($past(ACC_OUT) & $past(REQ.mem_rdata)) == 8'h00)))
    else $error("AND into memory zero flag wrong");

  chk_refused_quiet: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.valid && (REQ.op == aad_pkg::OP_NONE || REQ.op > aad_pkg::OP_LOAD_ACC_IMM)) |=>
      (!DONE && !MEM_WR.we && $stable(ACC_OUT) && $stable(FLAGS_OUT)
       && $stable(MEM_WR.wdata)))
    else $error("refused op code changed state");

  chk_done_known: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.valid && REQ.op >= aad_pkg::OP_ADD_ACC_INTO_MEMORY
     && REQ.op <= aad_pkg::OP_LOAD_ACC_IMM) |=> DONE)
    else $error("accepted request gave no done pulse");

  chk_we_source: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    MEM_WR.we |-> ($past(REQ.valid) && ($past(REQ.op) == aad_pkg::OP_ADD_ACC_INTO_MEMORY
                                       || $past(REQ.op) == aad_pkg::OP_AND_ACC_INTO_MEMORY)))
    else $error("memory write-back without a storing request");

  chk_wdata_holds: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !MEM_WR.we |-> $stable(MEM_WR.wdata))
    else $error("write-back data moved without a write");

  chk_done_source: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    DONE |-> $past(REQ.valid))
    else $error("done pulse without a request");

  chk_load_keeps_flags: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.valid && REQ.op == aad_pkg::OP_LOAD_ACC_IMM) |=>
      (ACC_OUT == $past(REQ.imm) && $stable(FLAGS_OUT) && !MEM_WR.we))
    else $error("accumulator load result or flags wrong");

endmodule // aad_datapath

// ===== test/aad_mem_model.sv
// Data-memory byte at the far side of the datapath
`timescale 1ns/1ns
module aad_mem_model (
  input  wire logic                  CLK_SYS,
  input  wire logic                  RST_N,
  input  wire aad_pkg::aad_mem_wr_t  MEM_WR,
  output logic [aad_pkg::DATA_W-1:0] MEM_Q
);
  // Follows each write-back so later requests read back results
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      MEM_Q <= 8'h5a;
    end else if (MEM_WR.we) begin
      MEM_Q <= MEM_WR.wdata;
    end
  end
endmodule // aad_mem_model

// ===== test/tb_aad_datapath.sv
// Self-checking bench for the add and AND datapath
`timescale 1ns/1ns
module tb_aad_datapath;
  logic                 CLK_SYS;
  logic                 RST_N;
  aad_pkg::aad_req_t    req;
  logic [7:0]           acc_out;
  aad_pkg::aad_flags_t  flags_out;
  aad_pkg::aad_mem_wr_t mem_wr;
  logic                 done;
  logic [7:0]           mem_q;
  int                   n_errors;
  int                   tests_run;
  int                   cycles;
  logic [7:0]           m_acc;
  logic [4:0]           m_flg;
  logic [8:0]           m_wr;
  logic                 m_done;

  aad_datapath uut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .REQ(req), .ACC_OUT(acc_out),
    .FLAGS_OUT(flags_out), .MEM_WR(mem_wr), .DONE(done));
  aad_mem_model mem (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .MEM_WR(mem_wr), .MEM_Q(mem_q));

  task automatic model(input logic [2:0] op, input logic [7:0] m, input logic [7:0] x);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] l;
    logic [7:0] r;
    logic       v;
    s = {1'b0, m_acc} + {1'b0, m};
    h = {1'b0, m_acc[3:0]} + {1'b0, m[3:0]};
    l = {1'b0, m_acc[6:0]} + {1'b0, m[6:0]};
    v = l[7] ^ s[8];
    r = m_acc & ((op == 3'h3) ? x : m);
    m_wr[8] = 1'b0;
    m_done = (op >= 3'h1) && (op <= 3'h5);
    case (op)
      3'h1: begin
        m_wr = {1'b1, s[7:0]};
        m_flg = {v, s[7:0] == 8'h00, h[4], s[8], v ^ s[7]};
      end
      3'h2, 3'h3: begin
        m_acc = r;
        m_flg[3] = (r == 8'h00);
      end
      3'h4: begin
        m_wr = {1'b1, r};
        m_flg[3] = (r == 8'h00);
      end
      3'h5: m_acc = x;
      default: ;
    endcase
  endtask

  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_acc(input logic [7:0] exp);
    check("acc", {1'b0, exp}, {1'b0, acc_out});
  endtask

  task automatic check_flags(input logic [4:0] exp);
    check("flags", {4'h0, exp}, {4'h0, flags_out});
  endtask

  task automatic check_wr(input logic [8:0] exp);
    check("mem_wr", exp, mem_wr);
  endtask

  task automatic check_done(input logic exp);
    check("done", {8'h00, exp}, {8'h00, done});
  endtask

  task automatic test_done();
    if (n_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Ceiling well above the 621 cycles that the sequence needs
  always @(posedge CLK_SYS) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      test_done();
    end
  end

  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end

  initial begin : main
    logic [2:0] op;
    RST_N = 1'b0;
    req = '0;
    n_errors = 0;
    tests_run = 0;
    cycles = 0;
    m_acc = 8'h00;
    m_flg = 5'h00;
    m_wr = 9'h000;
    m_done = 1'b0;
    void'($urandom(26751));
    repeat (20) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    RST_N = 1'b1;
    for (int i = 0; i < 600; i++) begin
      // Second reset in mid-run: outputs must restart from reset values
      if (i == 300) begin
        RST_N = 1'b0;
        m_acc = 8'h00;
        m_flg = 5'h00;
        m_wr = 9'h000;
        @(negedge CLK_SYS);
        RST_N = 1'b1;
      end
      // First eight requests walk every op code, refused ones too
      op = (i < 8) ? 3'(i) : 3'($urandom_range(7));
      req.valid = (i < 8) || ($urandom_range(7) != 0);
      req.op = aad_pkg::aad_op_t'(op);
      req.mem_rdata = $urandom_range(1) ? mem_q : 8'($urandom);
      req.imm = 8'($urandom);
      model(req.valid ? op : 3'h0, req.mem_rdata, req.imm);
      @(negedge CLK_SYS);
      check_acc(m_acc);
      check_flags(m_flg);
      check_wr(m_wr);
      check_done(m_done);
    end
    test_done();
  end
endmodule // tb_aad_datapath
